// ### core/ctg_cfg.svh
`ifndef CTG_CFG_SVH
`define CTG_CFG_SVH
// Register byte offsets
`define CTG_A_CH1_CFG   8'h00
`define CTG_A_CH2_CFG   8'h04
`define CTG_A_CH1_LVL   8'h08
`define CTG_A_CH2_LVL   8'h0c
`define CTG_A_CH3_EVT   8'h10
`define CTG_A_ROUTE     8'h14
`define CTG_A_ARM       8'h18
`define CTG_A_GATE      8'h1c
`define CTG_A_CTRL      8'h20
// Channel config fields
`define CTG_F_HYST      0
`define CTG_F_AUTO      7
`define CTG_F_PCT       8
`define CTG_F_SLOPE     15
`define CTG_F_ATTEN     16
// Control fields
`define CTG_F_INIT      0
`define CTG_F_CONT      1
`define CTG_F_ERR       2
// Reset values
`define CTG_RST_HYST    7'd0
`define CTG_RST_HYST_LG 7'd100
`define CTG_RST_PCT     7'd50
`define CTG_RST_DIGITS  4'd4
`define CTG_RST_GATE    27'd10000
// Legal ranges, gate in 10 us units
`define CTG_HYST_MID    7'd50
`define CTG_HYST_MAX    7'd100
`define CTG_PCT_MAX     7'd100
`define CTG_PCT_STEP    7'd10
`define CTG_DIG_MIN     4'd3
`define CTG_DIG_MAX     4'd15
`define CTG_LVL_MAX     12'sd1025
`define CTG_GATE_MIN    27'd100
`define CTG_GATE_LONG   27'd10000
`define CTG_GATE_MAX    27'd100000000
`define CTG_GATE_STEP   27'd100
// Timing
`define CTG_CLK_NS      50
`define CTG_TICK_NS     10000
`define CTG_TICK_CYC    ((`CTG_TICK_NS + `CTG_CLK_NS - 1) / `CTG_CLK_NS)
`endif

// ### core/ctg_pkg.sv
package ctg_pkg;
    typedef enum logic [1:0] {
        CTG_STOP_IMM = 2'd0,
        CTG_STOP_EXT = 2'd1,
        CTG_STOP_TIM = 2'd2,
        CTG_STOP_DIG = 2'd3
    } ctg_stop_e;
    typedef enum logic [2:0] {
        CTG_C_IDLE = 3'b001,
        CTG_C_MUL  = 3'b010,
        CTG_C_DONE = 3'b100
    } ctg_calc_e;
    typedef enum logic [2:0] {
        CTG_G_IDLE = 3'b001,
        CTG_G_WAIT = 3'b010,
        CTG_G_OPEN = 3'b100
    } ctg_gate_e;
    typedef struct packed {
        logic        slope;
        logic        atten;
        logic        auto_en;
        logic [6:0]  auto_level_percent;
        logic [6:0]  hysteresis_percent;
        logic [11:0] level;
    } ctg_chan_s;
    typedef struct packed {
        logic        start_ext;
        logic        start_edge;
        ctg_stop_e   stop_src;
        logic        stop_edge;
        logic [3:0]  digits;
    } ctg_arm_s;
    // Legal start/stop source pairs
    function automatic logic ctg_pair_ok(input ctg_arm_s a);
        return a.start_ext ? (a.stop_src != CTG_STOP_DIG)
                           : (a.stop_src != CTG_STOP_EXT);
    endfunction
endpackage

// ### core/ctg_lvl_calc.sv
`timescale 1ns/1ps
`default_nettype none
module ctg_lvl_calc
    import ctg_pkg::*;
(
    input  wire logic        i_clk_sys, // System clock
    input  wire logic        i_sys_rst, // Async reset
    input  wire logic        i_start,   // Recompute request
    input  wire logic [11:0] i_min,     // Low peak code
    input  wire logic [11:0] i_max,     // High peak code
    input  wire logic [3:0]  i_tenths,  // Percentage over ten
    output logic             o_busy,    // Calculation running
    output logic [11:0]      o_level    // Computed level code
);
    typedef struct packed {
        ctg_calc_e   st;
        logic [11:0] lo;
        logic [15:0] prod;
        logic [11:0] level;
    } ctg_calc_s;
    ctg_calc_s          st_ff;
    ctg_calc_s          nxt_st;
    logic signed [12:0] span;

    // Level is low peak plus the chosen share of the span
    always_comb
    begin
        span = $signed({i_max[11], i_max}) - $signed({i_min[11], i_min});
        nxt_st = st_ff;
        case (st_ff.st)
            CTG_C_IDLE:
            begin
                if (i_start)
                begin
                    nxt_st.lo = i_min;
                    nxt_st.prod = span[12] ? 16'h0
                        : {4'h0, span[11:0]} * {12'h0, i_tenths};
                    nxt_st.st = CTG_C_MUL;
                end
            end
            CTG_C_MUL:
            begin
                nxt_st.level = st_ff.lo + 12'(st_ff.prod / 16'd10);
                nxt_st.st = CTG_C_DONE;
            end
            CTG_C_DONE:
                nxt_st.st = CTG_C_IDLE;
            default:
                nxt_st.st = CTG_C_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            st_ff <= '{st: CTG_C_IDLE, default: '0};
        else
            st_ff <= nxt_st;
    end

    assign o_busy  = (st_ff.st != CTG_C_IDLE);
    assign o_level = st_ff.level;
endmodule
`default_nettype wire

// ### core/ctg_arm_core.sv
`include "ctg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ctg_arm_core
    import ctg_pkg::*;
#(
    parameter bit          LEGACY    = 1'b0,          // Sensitivity meaning
    parameter logic [11:0] HYST_HALF = 12'd40,        // Full half window
    parameter int          TICK_CYC  = `CTG_TICK_CYC  // Cycles per 10 us
)(
    input  wire logic            i_clk_sys,         // 20 MHz clock
    input  wire logic            i_sys_rst,         // Async reset
    input  wire logic [7:0]      i_avs_address,     // Byte address
    input  wire logic            i_avs_read,        // Read request
    input  wire logic            i_avs_write,       // Write request
    input  wire logic [31:0]     i_avs_writedata,   // Write data
    input  wire logic [3:0]      i_avs_byteenable,  // Byte lanes
    output logic [31:0]          o_avs_readdata,    // Read data
    output logic                 o_avs_waitrequest, // Stall
    input  wire logic [1:0][11:0] i_peak_min,       // Low peaks per chan
    input  wire logic [1:0][11:0] i_peak_max,       // High peaks per chan
    input  wire logic [1:0]      i_no_trig,         // No triggering seen
    input  wire logic            i_edge_indep,      // Edge-fixed function
    input  wire logic            i_ext_arm,         // External arm pin
    input  wire logic            i_meas_done,       // Datapath stop
    output logic [1:0][12:0]     o_thr,             // Comparator levels
    output logic [1:0]           o_edge_fall,       // Falling edge used
    output logic [1:0]           o_atten_x10,       // Tenfold attenuator
    output logic                 o_ch2_from_ch1,    // Common routing
    output logic                 o_meas_init,       // Start pulse
    output logic                 o_cont,            // Continuous mode
    output logic                 o_gate_open,       // Gate window
    output var ctg_arm_s         o_arm              // Arm settings
);
    localparam int TW = $clog2(TICK_CYC + 1);
    localparam ctg_chan_s CH_RST = '{
        slope: 1'b0, atten: 1'b0, auto_en: 1'b1,
        auto_level_percent: `CTG_RST_PCT,
        hysteresis_percent: LEGACY ? `CTG_RST_HYST_LG : `CTG_RST_HYST,
        level: 12'h0};
    localparam ctg_arm_s ARM_RST = '{
        start_ext: 1'b0, start_edge: 1'b0, stop_src: CTG_STOP_TIM,
        stop_edge: 1'b1, digits: `CTG_RST_DIGITS};

    typedef struct packed {
        ctg_chan_s [1:0]  ch;
        ctg_arm_s         arm;
        logic             channel_two_routing;
        logic [26:0]      gate;
        logic             cont;
        logic             err;
        logic             init;
        logic             ack;
        logic [31:0]      rdata;
        logic [2:0]       sync;
        ctg_gate_e        gst;
        logic [TW-1:0]    tick_cnt;
        logic [26:0]      gate_cnt;
        logic [1:0]       fall;
        logic [1:0][12:0] thr;
    } ctg_core_s;

    ctg_core_s        st_ff;
    ctg_core_s        nxt_st;
    logic [31:0]      rv;
    logic [31:0]      m;
    logic [31:0]      wv;
    logic [31:0]      wm;
    logic             sel;
    logic [1:0]       rc;
    logic [1:0]       pct_wr;
    logic [1:0]       lvl_acc;
    logic [1:0]       busy;
    logic [1:0][11:0] auto_lvl;
    logic [1:0][11:0] lvl_eff;
    logic             err_set;
    logic             err_clr;
    logic             start_meas;
    logic             arm_go;
    logic             stop;
    logic             tick;
    logic             ext_rise;
    logic             ext_fall;
    logic [6:0]       eff;
    logic [11:0]      h;
    logic             f;
    logic [26:0]      g;
    ctg_arm_s         arm_w;
    ctg_chan_s        cs;

    // Edges of the synchronised external arm pin
    assign ext_rise = st_ff.sync[1] & ~st_ff.sync[2];
    assign ext_fall = ~st_ff.sync[1] & st_ff.sync[2];

    // Per channel level engine and effective level
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_ch
            logic [11:0] pmin;
            logic [11:0] pmax;
            // Common routing feeds channel one into channel two
            assign pmin = (i == 1 && st_ff.channel_two_routing)
                          ? i_peak_min[0] : i_peak_min[i];
            assign pmax = (i == 1 && st_ff.channel_two_routing)
                          ? i_peak_max[0] : i_peak_max[i];
            // Recompute on start, percent write or lost trigger
            assign rc[i] = nxt_st.ch[i].auto_en
                           & (st_ff.init | pct_wr[i] | i_no_trig[i]);
            // Auto level replaces the written one while enabled
            assign lvl_eff[i] = st_ff.ch[i].auto_en ? auto_lvl[i]
                                                    : st_ff.ch[i].level;
            ctg_lvl_calc u_calc (
                .i_clk_sys (i_clk_sys),
                .i_sys_rst (i_sys_rst),
                .i_start   (rc[i]),
                .i_min     (pmin),
                .i_max     (pmax),
                // Percent being written this cycle, not the stale one
                .i_tenths  (4'(nxt_st.ch[i].auto_level_percent
                               / `CTG_PCT_STEP)),
                .o_busy    (busy[i]),
                .o_level   (auto_lvl[i])
            );
        end
    endgenerate

    // Bus decode, register writes, gate sequencing and thresholds
    always_comb
    begin
        nxt_st = st_ff;
        pct_wr = 2'b00;
        lvl_acc = 2'b00;
        err_set = 1'b0;
        err_clr = 1'b0;
        start_meas = 1'b0;
        arm_go = 1'b0;
        stop = 1'b0;
        eff = 7'h0;
        h = 12'h0;
        f = 1'b0;
        sel = i_avs_address[2];
        cs = st_ff.ch[sel];
        m = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
             {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
        // Readback; third channel is fixed zero level, rising
        case (i_avs_address)
            `CTG_A_CH1_CFG, `CTG_A_CH2_CFG:
                rv = {15'h0, cs.atten, cs.slope, cs.auto_level_percent,
                      cs.auto_en, cs.hysteresis_percent};
            `CTG_A_CH1_LVL, `CTG_A_CH2_LVL:
                rv = {{20{lvl_eff[sel][11]}}, lvl_eff[sel]};
            `CTG_A_ROUTE:
                rv = {31'h0, st_ff.channel_two_routing};
            `CTG_A_ARM:
                rv = {20'h0, st_ff.arm.digits, 3'h0, st_ff.arm.stop_edge,
                      st_ff.arm.stop_src, st_ff.arm.start_edge,
                      st_ff.arm.start_ext};
            `CTG_A_GATE:
                rv = {5'h0, st_ff.gate};
            `CTG_A_CTRL:
                rv = {26'h0, busy, o_gate_open, st_ff.err, st_ff.cont, 1'b0};
            default:
                rv = 32'h0;
        endcase
        wv = (rv & ~m) | (i_avs_writedata & m);
        wm = i_avs_writedata & m;
        g = wv[26:0];
        arm_w = '{start_ext: wv[0], start_edge: wv[1],
                  stop_src: ctg_stop_e'(wv[3:2]), stop_edge: wv[4],
                  digits: wv[11:8]};
        // Two-cycle answer: data captured, then waitrequest drops
        nxt_st.ack = (i_avs_read | i_avs_write) & ~st_ff.ack;
        if (!st_ff.ack)
            nxt_st.rdata = rv;
        if (i_avs_write && st_ff.ack)
        begin
            case (i_avs_address)
                `CTG_A_CH1_CFG, `CTG_A_CH2_CFG:
                begin
                    // Only the three legal hysteresis steps stick
                    if (wv[6:0] == 7'd0 || wv[6:0] == `CTG_HYST_MID
                        || wv[6:0] == `CTG_HYST_MAX)
                        nxt_st.ch[sel].hysteresis_percent = wv[6:0];
                    nxt_st.ch[sel].auto_en = wv[`CTG_F_AUTO];
                    if (wv[14:8] <= `CTG_PCT_MAX
                        && (wv[14:8] % `CTG_PCT_STEP) == 7'd0)
                    begin
                        nxt_st.ch[sel].auto_level_percent = wv[14:8];
                        pct_wr[sel] = i_avs_byteenable[1];
                    end
                    nxt_st.ch[sel].slope = wv[`CTG_F_SLOPE];
                    nxt_st.ch[sel].atten = wv[`CTG_F_ATTEN];
                end
                `CTG_A_CH1_LVL, `CTG_A_CH2_LVL:
                begin
                    // In-range level is taken and auto is switched off
                    if ($signed(wv[11:0]) <= `CTG_LVL_MAX
                        && $signed(wv[11:0]) >= -`CTG_LVL_MAX)
                    begin
                        nxt_st.ch[sel].level = wv[11:0];
                        nxt_st.ch[sel].auto_en = 1'b0;
                        lvl_acc[sel] = 1'b1;
                    end
                end
                `CTG_A_ROUTE:
                    nxt_st.channel_two_routing = wv[0];
                `CTG_A_ARM:
                begin
                    // Illegal pairs or digits leave settings and flag
                    if (ctg_pair_ok(arm_w) && arm_w.digits >= `CTG_DIG_MIN)
                        nxt_st.arm = arm_w;
                    else
                        err_set = 1'b1;
                end
                `CTG_A_GATE:
                begin
                    if ((g >= `CTG_GATE_MIN && g < `CTG_GATE_LONG)
                        || (g >= `CTG_GATE_LONG && g <= `CTG_GATE_MAX
                        && (g % `CTG_GATE_STEP) == 27'd0))
                        nxt_st.gate = g;
                    else
                        err_set = 1'b1;
                end
                `CTG_A_CTRL:
                begin
                    err_clr = wm[`CTG_F_ERR];
                    start_meas = wm[`CTG_F_INIT]
                               | (wv[`CTG_F_CONT] & ~st_ff.cont);
                    nxt_st.cont = wv[`CTG_F_CONT];
                end
                default:
                    ;
            endcase
        end
        nxt_st.init = start_meas;
        // A new error beats a clear in the same cycle
        nxt_st.err = err_set | (st_ff.err & ~err_clr);
        nxt_st.sync = {st_ff.sync[1:0], i_ext_arm};
        // Gate sequencer
        tick = (st_ff.tick_cnt == TW'(TICK_CYC - 1));
        case (st_ff.gst)
            CTG_G_IDLE:
                arm_go = st_ff.init;
            CTG_G_WAIT:
            begin
                // Start edge matters only with external start
                if (st_ff.arm.start_edge ? ext_fall : ext_rise)
                    nxt_st.gst = CTG_G_OPEN;
            end
            CTG_G_OPEN:
            begin
                nxt_st.tick_cnt = tick ? TW'(0) : st_ff.tick_cnt + TW'(1);
                if (tick)
                    nxt_st.gate_cnt = st_ff.gate_cnt + 27'd1;
                case (st_ff.arm.stop_src)
                    CTG_STOP_TIM:
                        stop = tick && (st_ff.gate_cnt + 27'd1 >= st_ff.gate);
                    CTG_STOP_EXT:
                        stop = st_ff.arm.stop_edge ? ext_fall : ext_rise;
                    default:
                        stop = i_meas_done;
                endcase
                if (stop)
                begin
                    arm_go = st_ff.cont;
                    nxt_st.gst = CTG_G_IDLE;
                end
            end
            default:
                nxt_st.gst = CTG_G_IDLE;
        endcase
        if (arm_go)
        begin
            nxt_st.gst = st_ff.arm.start_ext ? CTG_G_WAIT : CTG_G_OPEN;
            nxt_st.tick_cnt = TW'(0);
            nxt_st.gate_cnt = 27'd0;
        end
        // Window edge from level, hysteresis and slope
        for (int i = 0; i < 2; i++)
        begin
            eff = LEGACY ? `CTG_HYST_MAX - st_ff.ch[i].hysteresis_percent
                         : st_ff.ch[i].hysteresis_percent;
            h = (eff == `CTG_HYST_MAX) ? HYST_HALF
              : (eff == `CTG_HYST_MID) ? {1'b0, HYST_HALF[11:1]} : 12'h0;
            f = st_ff.ch[i].slope & ~i_edge_indep;
            nxt_st.fall[i] = f;
            nxt_st.thr[i] = {lvl_eff[i][11], lvl_eff[i]}
                          + (f ? -{1'b0, h} : {1'b0, h});
        end
    end

    // State register; reset loads the documented defaults
    always_ff @(posedge i_clk_sys or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            st_ff <= '{ch: '{CH_RST, CH_RST}, arm: ARM_RST,
                       gate: `CTG_RST_GATE, gst: CTG_G_IDLE, default: '0};
        else
            st_ff <= nxt_st;
    end

    // Outputs
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_ff.ack;
    assign o_avs_readdata    = st_ff.rdata;
    assign o_thr             = st_ff.thr;
    assign o_edge_fall       = st_ff.fall;
    assign o_atten_x10       = {st_ff.ch[1].atten, st_ff.ch[0].atten};
    assign o_ch2_from_ch1    = st_ff.channel_two_routing;
    assign o_meas_init       = st_ff.init;
    assign o_cont            = st_ff.cont;
    assign o_gate_open       = (st_ff.gst == CTG_G_OPEN);
    assign o_arm             = st_ff.arm;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    sequence s_wait_start;
        st_ff.gst == CTG_G_WAIT
        && (st_ff.arm.start_edge ? ext_fall : ext_rise);
    endsequence

    chk_hyst_legal: assert property (
        st_ff.ch[1].hysteresis_percent inside {7'd0, 7'd50, 7'd100})
        else $error("hysteresis percent illegal");
    chk_hyst_reset: assert property (
        $past(i_sys_rst) |-> st_ff.ch[0].hysteresis_percent
            == (LEGACY ? `CTG_RST_HYST_LG : `CTG_RST_HYST))
        else $error("hysteresis reset value wrong");
    chk_lvl_auto_off: assert property (
        lvl_acc[1] |=> !st_ff.ch[1].auto_en && lvl_eff[1] == $past(wv[11:0]))
        else $error("level write kept auto enable");
    chk_auto_readbk: assert property (
        i_avs_read && !st_ff.ack && i_avs_address == `CTG_A_CH1_LVL
        && st_ff.ch[0].auto_en |=> st_ff.rdata[11:0] == $past(auto_lvl[0]))
        else $error("auto level not returned");
    chk_init_recalc: assert property (
        st_ff.init && st_ff.ch[0].auto_en && !busy[0] && !lvl_acc[0]
        |=> busy[0] ##2 !busy[0])
        else $error("no recompute on start");
    chk_pct_legal: assert property (
        st_ff.ch[0].auto_level_percent <= 7'd100
        && st_ff.ch[0].auto_level_percent % 7'd10 == 7'd0)
        else $error("auto percent illegal");
    chk_ch3_fixed: assert property (
        i_avs_read && !st_ff.ack && i_avs_address == `CTG_A_CH3_EVT
        |=> o_avs_readdata == 32'h0 && !o_avs_waitrequest)
        else $error("third channel not fixed");
    chk_arm_pair: assert property (
        ctg_pair_ok(st_ff.arm) && st_ff.arm.digits >= 4'd3)
        else $error("illegal arm pair held");
    chk_start_edge: assert property (
        s_wait_start |=> o_gate_open)
        else $error("gate did not open on start edge");
    chk_gate_range: assert property (
        st_ff.gate >= 27'd100 && st_ff.gate <= 27'd100000000)
        else $error("gate time out of range");
endmodule
`default_nettype wire

// ### verif/ctg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Remote controller: Avalon-MM master for configuration
module ctg_host_model (
    input  wire logic        i_clk_sys, // System clock
    input  wire logic        i_wait,    // Slave stall
    input  wire logic [31:0] i_rdata,   // Read data
    output logic [7:0]       o_addr,    // Byte address
    output logic             o_rd,      // Read request
    output logic             o_wr,      // Write request
    output logic [31:0]      o_wdata    // Write data
);
    // Idle bus
    initial
    begin
        o_addr = 8'h00;
        o_rd = 1'b0;
        o_wr = 1'b0;
        o_wdata = 32'h0;
    end
    // Request held until stall is low at a rising edge; data taken there
    task automatic xfer(input logic r, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        o_addr <= a;
        o_wdata <= d;
        o_rd <= r;
        o_wr <= !r;
        @(posedge i_clk_sys);
        while (i_wait)
            @(posedge i_clk_sys);
        q = i_rdata;
        o_rd <= 1'b0;
        o_wr <= 1'b0;
        @(posedge i_clk_sys);
    endtask
endmodule
`default_nettype wire

// ### verif/counter_trigger_and_gate_arming_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctg_cfg.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("FAIL %0t got %h exp %h", $time, a, b); end end
module counter_trigger_and_gate_arming_test;
    logic             clk_sys = 1'b0;
    logic             sys_rst = 1'b1;
    logic             wt, rd, wr, gopen, rte;
    logic [7:0]       ad;
    logic [31:0]      rdat, wdat, e, d;
    logic [1:0][11:0] pmin = '0, pmax = '0;
    logic [1:0]       ntrig = 2'b00;
    logic             xarm = 1'b0, eind = 1'b0;
    logic [1:0][12:0] thr;
    logic [1:0]       efall, atx;
    logic [8:0]       arm;
    int               miscompares = 0, checks_done = 0;
    // Clock, 50 ns period
    always #25 clk_sys = ~clk_sys;
    ctg_host_model u_host (.i_clk_sys(clk_sys), .i_wait(wt), .i_rdata(rdat),
        .o_addr(ad), .o_rd(rd), .o_wr(wr), .o_wdata(wdat));
    ctg_arm_core #(.TICK_CYC(2)) u_dut (.i_clk_sys(clk_sys),
        .i_sys_rst(sys_rst), .i_avs_address(ad), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_peak_min(pmin),
        .i_peak_max(pmax), .i_no_trig(ntrig), .i_edge_indep(eind),
        .i_ext_arm(xarm), .i_meas_done(1'b0), .o_thr(thr),
        .o_edge_fall(efall), .o_atten_x10(atx), .o_ch2_from_ch1(rte),
        .o_meas_init(), .o_cont(), .o_gate_open(gopen), .o_arm(arm));
    // Bus helpers
    task automatic wrr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] q;
        u_host.xfer(1'b0, a, v, q);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        u_host.xfer(1'b1, a, 32'h0, q);
        `CHK(q, x)
    endtask
    // Counts, verdict and end of run
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        test_done;
    end
    // Test sequence
    initial
    begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        rdchk(`CTG_A_CH1_CFG, 32'h3280);
        rdchk(`CTG_A_ARM, 32'h418);
        rdchk(`CTG_A_GATE, 32'h2710);
        rdchk(`CTG_A_ROUTE, 32'h0);
        $display("defaults done");
        wrr(`CTG_A_CH1_CFG, 32'h32b2);
        wrr(`CTG_A_CH1_CFG, 32'h329e);
        rdchk(`CTG_A_CH1_CFG, 32'h32b2);
        wrr(`CTG_A_CH1_CFG, 32'h32e4);
        rdchk(`CTG_A_CH1_CFG, 32'h32e4);
        $display("hysteresis done");
        wrr(`CTG_A_GATE, 32'h64);
        pmax[0] <= 12'd100;
        wrr(`CTG_A_CTRL, 32'h1);
        repeat (8) @(posedge clk_sys);
        rdchk(`CTG_A_CH1_LVL, 32'h32);
        `CHK(gopen, 1'b1)
        wrr(`CTG_A_CH1_CFG, 32'h1ee4);
        repeat (8) @(posedge clk_sys);
        rdchk(`CTG_A_CH1_LVL, 32'h1e);
        pmax[0] <= 12'd200;
        ntrig <= 2'b01;
        @(posedge clk_sys);
        ntrig <= 2'b00;
        repeat (8) @(posedge clk_sys);
        rdchk(`CTG_A_CH1_LVL, 32'h3c);
        repeat (250) @(posedge clk_sys);
        `CHK(gopen, 1'b0)
        $display("auto level done");
        wrr(`CTG_A_CH2_LVL, 32'h401);
        wrr(`CTG_A_CH2_LVL, 32'h402);
        rdchk(`CTG_A_CH2_LVL, 32'h401);
        rdchk(`CTG_A_CH2_CFG, 32'h3200);
        rdchk(`CTG_A_CH1_CFG, 32'h1ee4);
        wrr(`CTG_A_CH2_LVL, 32'hfffffbff);
        rdchk(`CTG_A_CH2_LVL, 32'hfffffbff);
        wrr(`CTG_A_CH3_EVT, 32'hffffffff);
        rdchk(`CTG_A_CH3_EVT, 32'h0);
        rdchk(8'h40, 32'h0);
        `CHK(thr[0], 13'd100)
        `CHK(thr[1], 13'h1bff)
        wrr(`CTG_A_CH1_CFG, 32'h19ee4);
        repeat (2) @(posedge clk_sys);
        `CHK(thr[0], 13'd20)
        `CHK(efall, 2'b01)
        `CHK(atx, 2'b01)
        eind <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(thr[0], 13'd100)
        `CHK(efall, 2'b00)
        eind <= 1'b0;
        $display("levels done");
        e = 32'h418;
        for (int i = 0; i < 8; i++)
        begin
            d = {20'h0, 4'h5, 4'h0, i[1:0], 1'b0, i[2]};
            if (i[2] ? (i[1:0] != 2'd3) : (i[1:0] != 2'd1))
                e = d;
            wrr(`CTG_A_ARM, d);
            rdchk(`CTG_A_ARM, e);
        end
        wrr(`CTG_A_ARM, 32'h20c);
        rdchk(`CTG_A_ARM, e);
        rdchk(`CTG_A_CTRL, 32'h4);
        wrr(`CTG_A_GATE, 32'h270f);
        wrr(`CTG_A_GATE, 32'h2742);
        rdchk(`CTG_A_GATE, 32'h270f);
        wrr(`CTG_A_GATE, 32'h2774);
        rdchk(`CTG_A_GATE, 32'h2774);
        wrr(`CTG_A_ROUTE, 32'h1);
        rdchk(`CTG_A_ROUTE, 32'h1);
        `CHK(rte, 1'b1)
        $display("arming done");
        wrr(`CTG_A_ARM, 32'h415);
        `CHK(arm, 9'h134)
        wrr(`CTG_A_CTRL, 32'h1);
        repeat (4) @(posedge clk_sys);
        `CHK(gopen, 1'b0)
        xarm <= 1'b1;
        repeat (5) @(posedge clk_sys);
        `CHK(gopen, 1'b1)
        xarm <= 1'b0;
        repeat (5) @(posedge clk_sys);
        `CHK(gopen, 1'b0)
        $display("external arm done");
        test_done;
    end
endmodule
`default_nettype wire
